/* bit_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input asynchronous to i_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module bit_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : bit_sync

/* pager_pkt_fmt.sv */
// Purpose: builds vector, message, status and part id packets for the host
// Assumes: decoder events are one-cycle pulses on i_clk; apb zero wait
// Notes: status flags clear when a status packet is loaded for the host
`timescale 1ns/1ps
module pager_pkt_fmt (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // host link
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe,
  output logic             o_host_prompt,
  // vector from decoder
  input  wire logic        i_vec_valid,
  input  wire logic [6:0]  i_vec_word_position,
  input  wire logic [1:0]  i_vec_phase,
  input  wire logic [2:0]  i_vec_type,
  input  wire logic        i_vec_long_addr,
  input  wire logic        i_vec_multi_err,
  input  wire logic        i_vec_check_fail,
  input  wire logic        i_vec_invalid,
  input  wire logic [2:0]  i_vec_instr,
  input  wire logic [3:0]  i_vec_temp_addr,
  input  wire logic [6:0]  i_vec_assigned_frame,
  input  wire logic [10:0] i_vec_instr_data,
  input  wire logic [6:0]  i_vec_msg_count,
  input  wire logic [6:0]  i_vec_msg_start,
  // message word from decoder
  input  wire logic        i_msg_valid,
  input  wire logic [6:0]  i_msg_word_position,
  input  wire logic [1:0]  i_msg_phase,
  input  wire logic        i_msg_multi_err,
  input  wire logic [20:0] i_msg_info,
  // frame and sync state
  input  wire logic        i_block0_end,
  input  wire logic        i_frame_info_seen,
  input  wire logic [6:0]  i_frame_num,
  input  wire logic [3:0]  i_cycle_num,
  input  wire logic        i_frame_end,
  input  wire logic        i_all_frames_nz,
  input  wire logic        i_temp_addr_nz,
  input  wire logic        i_sync_found,
  input  wire logic        i_sync_lost,
  input  wire logic        i_search_expired,
  input  wire logic        i_minute,
  input  wire logic        i_battery_poll,
  input  wire logic        i_battery_detect_input,
  input  wire logic        i_checksum_disabled,
  output logic             o_decode_on
);
  localparam int QDEPTH = pager_pkt_pkg::QDEPTH;
  localparam int QAW    = pager_pkt_pkg::QAW;
  logic [4:0]  ctrl_q;
  logic        frame_info_ok_q, sync_locked_q, battery_level_q, first_upd_q;
  logic        sync_change_flag_q, battery_change_flag_q, minute_tick_flag_q;
  logic        eof_flag_q, tx_overflow_flag_q, last_sample_q, sample_ok_q;
  logic [6:0]  frame_q;
  logic [3:0]  cycle_q;
  logic        part_pend_q, chk_d_q, msg_allow_q, on_d_q, bat_s;
  logic [31:0] q_mem [QDEPTH];
  logic [QAW:0] wr_q, rd_q;
  logic        q_empty, q_full, push, ovf, load, pop, sel_status, stat_clr;
  logic [31:0] push_word, vec_word, msg_word, status_word, part_word, load_word;
  logic        vec_err, msg_vec, on_rise, on_fall, apb_wr;

  bit_sync u_bat (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_battery_detect_input), .o_q(bat_s));

  spi_shift_tx u_tx (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_sck     (i_spi_sck),
    .i_cs_n    (i_spi_cs_n),
    .i_word    (load_word),
    .o_load    (load),
    .o_miso    (o_spi_miso),
    .o_miso_oe (o_spi_miso_oe)
  );

  // apb slave, zero wait states
  assign o_pready  = 1'b1;
  assign apb_wr    = i_psel & i_penable & i_pwrite & (i_paddr == pager_pkt_pkg::ADDR_CTRL);
  assign o_pslverr = i_psel & i_penable & ~(i_paddr == pager_pkt_pkg::ADDR_CTRL
                     | (~i_pwrite & (i_paddr == pager_pkt_pkg::ADDR_STATUS
                     | i_paddr == pager_pkt_pkg::ADDR_PARTID)));
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (i_psel && !i_pwrite) begin
      unique case (i_paddr)
        pager_pkt_pkg::ADDR_CTRL:   o_prdata = {27'h0, ctrl_q};
        pager_pkt_pkg::ADDR_STATUS: o_prdata = status_word;
        pager_pkt_pkg::ADDR_PARTID: o_prdata = part_word;
        default:                    o_prdata = 32'h0000_0000;
      endcase
    end
  end

  assign ovf         = push & q_full;
  assign o_decode_on = ctrl_q[pager_pkt_pkg::CTRL_ON];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= pager_pkt_pkg::CTRL_RESET;
    end else begin
      if (apb_wr) begin
        ctrl_q <= i_pwdata[4:0];
      end
      if (ovf) begin
        ctrl_q[pager_pkt_pkg::CTRL_ON] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_d_q <= 1'b0;
    end else begin
      on_d_q <= o_decode_on;
    end
  end
  assign on_rise = o_decode_on & ~on_d_q;
  assign on_fall = ~o_decode_on & on_d_q;

  // vector packet
  assign msg_vec = (i_vec_type == pager_pkt_pkg::VT_SECURE) | (i_vec_type == pager_pkt_pkg::VT_ALPHA)
                   | (i_vec_type == pager_pkt_pkg::VT_HEX);
  assign vec_err = i_vec_multi_err | i_vec_check_fail | i_vec_invalid
                   | (msg_vec & (i_vec_msg_count < pager_pkt_pkg::CNT_MIN
                   | i_vec_msg_count > pager_pkt_pkg::CNT_MAX
                   | i_vec_msg_start < pager_pkt_pkg::MSG_POS_MIN
                   | i_vec_msg_start > pager_pkt_pkg::POS_MAX));
  always_comb begin
    logic [10:0] d;
    d = i_vec_instr_data;
    if (i_vec_instr == pager_pkt_pkg::INSTR_TEMP) begin
      d = {i_vec_temp_addr, i_vec_assigned_frame};
    end
    vec_word = {1'b0, i_vec_word_position, vec_err, i_vec_phase, 2'b00, i_vec_type,
                2'b00, i_vec_msg_count, i_vec_msg_start};
    if (i_vec_type == pager_pkt_pkg::VT_SHORT_INSTR) begin
      vec_word[13:0] = {d, i_vec_instr};
    end
  end

  assign msg_word = {1'b0, i_msg_word_position, i_msg_multi_err, i_msg_phase, i_msg_info};

  // message words allowed only after an error free vector that owns them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      msg_allow_q <= 1'b0;
    end else if (i_vec_valid) begin
      msg_allow_q <= ~vec_err & (msg_vec
                     | (i_vec_type == pager_pkt_pkg::VT_SHORT_INSTR & i_vec_long_addr));
    end else if (i_frame_end) begin
      msg_allow_q <= 1'b0;
    end
  end

  assign push      = o_decode_on & (i_vec_valid | (i_msg_valid & msg_allow_q));
  assign push_word = i_vec_valid ? vec_word : msg_word;

  // transmit queue
  assign q_empty = (wr_q == rd_q);
  assign q_full  = (wr_q[QAW] != rd_q[QAW]) && (wr_q[QAW-1:0] == rd_q[QAW-1:0]);
  assign pop     = load & ~part_pend_q & ~q_empty;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (ovf) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (push && !q_full) begin
      q_mem[wr_q[QAW-1:0]] <= push_word;
    end
  end

  // part id pending after reset and on each checksum disable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      part_pend_q <= 1'b1;
      chk_d_q     <= 1'b1;
    end else begin
      chk_d_q <= i_checksum_disabled;
      if (i_checksum_disabled && !chk_d_q) begin
        part_pend_q <= 1'b1;
      end else if (load) begin
        part_pend_q <= 1'b0;
      end
    end
  end

  assign part_word  = {pager_pkt_pkg::PART_ID, pager_pkt_pkg::MODEL_CODE, pager_pkt_pkg::COMPAT_CODE,
                       pager_pkt_pkg::REVISION_CODE};
  assign status_word = {pager_pkt_pkg::STATUS_ID, frame_info_ok_q, frame_q,
                        sync_locked_q, battery_level_q, 2'b00, cycle_q,
                        sync_change_flag_q, battery_change_flag_q, 1'b0, minute_tick_flag_q,
                        1'b0, eof_flag_q, 1'b0, tx_overflow_flag_q};
  assign sel_status = ~part_pend_q & q_empty;
  assign stat_clr   = load & sel_status;
  assign load_word  = part_pend_q ? part_word : (q_empty ? status_word : q_mem[rd_q[QAW-1:0]]);

  // sync, frame info, frame and cycle numbers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_locked_q   <= 1'b0;
      frame_info_ok_q <= 1'b0;
      frame_q         <= 7'h00;
      cycle_q         <= 4'h0;
    end else begin
      if (i_block0_end) begin
        frame_q <= i_frame_num;
        cycle_q <= i_cycle_num;
      end
      if (on_fall) begin
        sync_locked_q   <= 1'b0;
        frame_info_ok_q <= 1'b0;
      end else if (o_decode_on) begin
        if (i_sync_lost) begin
          sync_locked_q   <= 1'b0;
          frame_info_ok_q <= 1'b0;
        end else begin
          if (i_sync_found) begin
            sync_locked_q <= 1'b1;
          end
          if (i_block0_end && i_frame_info_seen && (sync_locked_q || i_sync_found)) begin
            frame_info_ok_q <= 1'b1;
          end
        end
      end
    end
  end

  // sync change flag; turn-off never sets it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      first_upd_q        <= 1'b0;
      sync_change_flag_q <= 1'b0;
    end else begin
      if (on_rise) begin
        first_upd_q <= 1'b1;
      end else if (o_decode_on && (i_sync_found || i_search_expired)) begin
        first_upd_q <= 1'b0;
      end
      if (o_decode_on && ((i_sync_found && !sync_locked_q) || (i_sync_lost && sync_locked_q)
          || (i_search_expired && first_upd_q))) begin
        sync_change_flag_q <= 1'b1;
      end else if (stat_clr) begin
        sync_change_flag_q <= 1'b0;
      end
    end
  end

  // battery level and change flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      battery_level_q       <= 1'b0;
      last_sample_q         <= 1'b0;
      sample_ok_q           <= 1'b0;
      battery_change_flag_q <= 1'b0;
    end else begin
      if (i_battery_poll) begin
        battery_level_q <= bat_s;
        last_sample_q   <= bat_s;
        sample_ok_q     <= 1'b1;
      end else if (on_rise) begin
        battery_level_q <= ~ctrl_q[pager_pkt_pkg::CTRL_BAT_POL];
      end
      if (i_battery_poll && sample_ok_q && (bat_s != last_sample_q)) begin
        battery_change_flag_q <= 1'b1;
      end else if (stat_clr) begin
        battery_change_flag_q <= 1'b0;
      end
    end
  end

  // minute, end of frame and overflow flags; set wins over clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      minute_tick_flag_q <= 1'b0;
      eof_flag_q         <= 1'b0;
      tx_overflow_flag_q <= 1'b0;
    end else begin
      minute_tick_flag_q <= i_minute | (minute_tick_flag_q & ~stat_clr);
      eof_flag_q <= (i_frame_end & (i_all_frames_nz | i_temp_addr_nz
                    | ctrl_q[pager_pkt_pkg::CTRL_FORCE_AF]))
                    | (eof_flag_q & ~stat_clr);
      tx_overflow_flag_q <= ovf | (tx_overflow_flag_q & ~stat_clr);
    end
  end

  assign o_host_prompt = ~q_empty | part_pend_q
                         | (sync_change_flag_q & ctrl_q[pager_pkt_pkg::CTRL_SYNC_EN])
                         | (minute_tick_flag_q & ctrl_q[pager_pkt_pkg::CTRL_MIN_EN])
                         | eof_flag_q | battery_change_flag_q | tx_overflow_flag_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  prompt_flags_a: assert property ((eof_flag_q || battery_change_flag_q || tx_overflow_flag_q)
    |-> o_host_prompt) else $error("prompt missing with pending flag");
  status_id_a: assert property (stat_clr |-> load_word[31:24] == 8'h7f)
    else $error("status packet id wrong");
  poll_status_a: assert property (load && !part_pend_q && q_empty |-> load_word == status_word)
    else $error("idle poll did not return status");
  overflow_a: assert property (push && q_full |=> !o_decode_on && tx_overflow_flag_q && q_empty)
    else $error("overflow not handled");
  part_id_a: assert property (load && part_pend_q |-> load_word[31:24] == 8'hff ##1 !part_pend_q)
    else $error("part id packet wrong");
  frame_ok_async_a: assert property (o_decode_on && i_sync_lost |=> !frame_info_ok_q && !sync_locked_q)
    else $error("frame info ok kept after sync loss");
  sync_found_a: assert property (o_decode_on && !on_fall && i_sync_found && !i_sync_lost
    |=> sync_locked_q) else $error("sync locked not set");
  turnon_bat_a: assert property (on_rise && !i_battery_poll && !battery_change_flag_q
    |=> !battery_change_flag_q && battery_level_q == !$past(ctrl_q[pager_pkt_pkg::CTRL_BAT_POL]))
    else $error("turn-on disturbed battery bits");
  minute_set_a: assert property (i_minute |=> minute_tick_flag_q)
    else $error("minute flag not set");
  vec_bit7_a: assert property (push |-> push_word[31] == 1'b0)
    else $error("packet bit 31 set");
  msg_gate_a: assert property (i_msg_valid && !i_vec_valid && !msg_allow_q |-> !push)
    else $error("message word sent without vector");
  cov_part_c: cover property (load && part_pend_q);
  cov_msg_c: cover property (i_vec_valid && push ##[1:20] i_msg_valid && push);
  cov_ovf_c: cover property (push && q_full);
endmodule : pager_pkt_fmt

/* pager_pkt_pkg.sv */
// Purpose: constants for the paging host packet formatter
// Assumes: packets are 32 bits, byte 3 sent first
package pager_pkt_pkg;
  localparam logic [7:0]  STATUS_ID      = 8'h7f;
  localparam logic [7:0]  PART_ID        = 8'hff;
  localparam logic [2:0]  VT_SHORT_INSTR = 3'h1;
  localparam logic [2:0]  VT_SECURE      = 3'h0;
  localparam logic [2:0]  VT_ALPHA       = 3'h5;
  localparam logic [2:0]  VT_HEX         = 3'h6;
  localparam logic [2:0]  INSTR_TEMP     = 3'h0;
  localparam logic [6:0]  VEC_POS_MIN    = 7'h02;
  localparam logic [6:0]  MSG_POS_MIN    = 7'h03;
  localparam logic [6:0]  POS_MAX        = 7'h57;
  localparam logic [6:0]  CNT_MIN        = 7'h01;
  localparam logic [6:0]  CNT_MAX        = 7'h55;
  // part id fields, values arbitrary
  localparam logic [1:0]  MODEL_CODE     = 2'h0;
  localparam logic [13:0] COMPAT_CODE    = 14'h0001;
  localparam logic [7:0]  REVISION_CODE  = 8'h00;
  // apb map
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_PARTID    = 8'h08;
  localparam int          CTRL_ON        = 0;
  localparam int          CTRL_SYNC_EN   = 1;
  localparam int          CTRL_MIN_EN    = 2;
  localparam int          CTRL_FORCE_AF  = 3;
  localparam int          CTRL_BAT_POL   = 4;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  localparam int          QDEPTH         = 4;
  localparam int          QAW            = 2;
endpackage : pager_pkt_pkg

/* spi_host_model.sv */
// Purpose: host side serial master model, mode 0, reads one packet per call
// Assumes: clock idles low, 80 ns period, select active low
// Notes: clock stands still between packets
`timescale 1ns/1ps
module spi_host_model (
  output logic      o_sck,
  output logic      o_cs_n,
  input  wire logic i_miso
);
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
  end
  task automatic read_packet(output logic [31:0] word);
    word = 32'h0;
    #3 o_cs_n = 1'b0;
    #120;
    for (int i = 31; i >= 0; i--) begin
      o_sck = 1'b1;
      word[i] = i_miso;
      #40 o_sck = 1'b0;
      #40;
    end
    o_cs_n = 1'b1;
    #300;
  endtask : read_packet
endmodule : spi_host_model

/* spi_shift_tx.sv */
// Purpose: slave serial shifter, mode 0, msb first
// Assumes: sck and cs_n come from pins, period well above 4 i_clk cycles
// Notes: asks for a word when select falls
`timescale 1ns/1ps
module spi_shift_tx (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic [31:0] i_word,
  output logic             o_load,
  output logic             o_miso,
  output logic             o_miso_oe
);
  logic        sck_s, cs_s, cs_n_s, sck_d_q, cs_d_q;
  logic [31:0] sh_q;
  bit_sync u_sck (.i_clk(i_clk), .i_rst(i_rst), .i_d(i_sck),  .o_q(sck_s));
  // select synchronised active high so reset reads as idle, no false load
  bit_sync u_cs  (.i_clk(i_clk), .i_rst(i_rst), .i_d(~i_cs_n), .o_q(cs_s));
  assign cs_n_s = ~cs_s;
  assign o_load = cs_d_q & ~cs_n_s;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_d_q <= 1'b0;
      cs_d_q  <= 1'b1;
    end else begin
      sck_d_q <= sck_s;
      cs_d_q  <= cs_n_s;
    end
  end
  // shift on falling sck so host samples on rising
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_q      <= 32'h0000_0000;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= ~cs_n_s;
      if (o_load) begin
        sh_q   <= {i_word[30:0], 1'b0};
        o_miso <= i_word[31];
      end else if (!cs_n_s && sck_d_q && !sck_s) begin
        sh_q   <= {sh_q[30:0], 1'b0};
        o_miso <= sh_q[31];
      end
    end
  end
endmodule : spi_shift_tx

/* testbench.sv */
// Purpose: self-checking bench for the host packet formatter
// Assumes: zero-wait register bus, host model reads whole packets
// Notes: unused packet bits are masked before comparing
`timescale 1ns/1ps
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin fail_count++; $display("wrong value at %0t: %h not %h", $time, g, x); end end
module testbench;
  logic        i_clk = 1'b0, i_rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, vv = 1'b0, vl = 1'b0;
  logic        vc = 1'b0, mv = 1'b0, me = 1'b0, pin = 1'b0, csum = 1'b0, fis = 1'b1, afz = 1'b0, e;
  logic        sck, cs_n, miso, moe, prompt, don, pready, perr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, w, r;
  logic [6:0]  vpos = 7'h00, vcnt = 7'h00, vst = 7'h00, mpos = 7'h00, ev = 7'h00, fnum = 7'h2a;
  logic [1:0]  vph = 2'h0, mph = 2'h0;
  logic [2:0]  vtyp = 3'h0, vins = 3'h0;
  logic [3:0]  cnum = 4'h9;
  logic [20:0] minfo = 21'h0;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  wire         line = moe ? miso : ~miso;
  pager_pkt_fmt pager_pkt_fmt_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_spi_sck(sck),
    .i_spi_cs_n(cs_n), .o_spi_miso(miso), .o_spi_miso_oe(moe), .o_host_prompt(prompt), .i_vec_valid(vv),
    .i_vec_word_position(vpos), .i_vec_phase(vph), .i_vec_type(vtyp), .i_vec_long_addr(vl),
    .i_vec_multi_err(vc), .i_vec_check_fail(vc), .i_vec_invalid(vc), .i_vec_instr(vins),
    .i_vec_temp_addr(vcnt[3:0]), .i_vec_assigned_frame(vst), .i_vec_instr_data({vst[3:0], vcnt}),
    .i_vec_msg_count(vcnt), .i_vec_msg_start(vst), .i_msg_valid(mv), .i_msg_word_position(mpos),
    .i_msg_phase(mph), .i_msg_multi_err(me), .i_msg_info(minfo), .i_block0_end(ev[0]),
    .i_frame_info_seen(fis), .i_frame_num(fnum), .i_cycle_num(cnum), .i_frame_end(ev[1]),
    .i_all_frames_nz(afz), .i_temp_addr_nz(afz), .i_sync_found(ev[2]), .i_sync_lost(ev[3]),
    .i_search_expired(ev[4]), .i_minute(ev[5]), .i_battery_poll(ev[6]), .i_battery_detect_input(pin),
    .i_checksum_disabled(csum), .o_decode_on(don));
  spi_host_model spi_host_model_i (.o_sck(sck), .o_cs_n(cs_n), .i_miso(line));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    r = prdata; e = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task automatic pulse(input int k);
    @(posedge i_clk) ev[k] <= 1'b1;
    @(posedge i_clk) ev <= 7'h00;
    repeat (3) @(posedge i_clk);
  endtask : pulse
  task automatic vec(input logic [6:0] p, input logic [1:0] ph, input logic [2:0] t, input logic l,
                     input logic c, input logic [6:0] n, input logic [6:0] s);
    @(posedge i_clk);
    vpos <= p; vph <= ph; vtyp <= t; vl <= l; vc <= c; vcnt <= n; vst <= s; vv <= 1'b1;
    @(posedge i_clk) vv <= 1'b0;
  endtask : vec
  task automatic msg(input logic [6:0] p, input logic [1:0] ph, input logic er, input logic [20:0] d);
    @(posedge i_clk);
    mpos <= p; mph <= ph; me <= er; minfo <= d; mv <= 1'b1;
    @(posedge i_clk) mv <= 1'b0;
  endtask : msg
  task automatic pkt();
    spi_host_model_i.read_packet(w);
  endtask : pkt
  task automatic t_regs();
    apb(1'b1, pager_pkt_pkg::ADDR_CTRL, 32'h3);
    apb(1'b0, pager_pkt_pkg::ADDR_CTRL, 32'h0);
    `CHK({e, r[4:0], don}, {1'b0, 5'h03, 1'b1})
    apb(1'b1, pager_pkt_pkg::ADDR_STATUS, 32'h1);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
  endtask : t_regs
  task automatic t_sync();
    pkt();
    `CHK(w & 32'hff80c0d5, 32'h7f004000)
    `CHK(prompt, 1'b0)
    pulse(2);
    pulse(0);
    `CHK(prompt, 1'b1)
    pkt();
    `CHK(w & 32'hffffcfd5, 32'h7faac980)
    pulse(5);
    `CHK(prompt, 1'b0)
    pkt();
    `CHK(w[7:0] & 8'hd5, 8'h10)
    pulse(3);
    pkt();
    `CHK(w & 32'hff80c0d5, 32'h7f004080)
  endtask : t_sync
  task automatic t_flags();
    pulse(1);
    `CHK(prompt, 1'b0)
    afz <= 1'b1;
    pulse(1);
    afz <= 1'b0;
    `CHK(prompt, 1'b1)
    apb(1'b1, pager_pkt_pkg::ADDR_CTRL, 32'hb);
    pulse(6);
    pin <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(6);
    pulse(1);
    `CHK(prompt, 1'b1)
    pkt();
    `CHK(w & 32'hff80c0d5, 32'h7f004044)
  endtask : t_flags
  task automatic t_vectors();
    vec(7'h05, 2'h2, 3'h1, 1'b1, 1'b0, 7'h0a, 7'h33);
    msg(7'h06, 2'h2, 1'b0, 21'h1abcde);
    vec(7'h07, 2'h1, 3'h5, 1'b0, 1'b0, 7'h55, 7'h03);
    msg(7'h03, 2'h1, 1'b1, 21'h12345);
    pkt();
    `CHK(w & 32'hffe73fff, {8'h05, 3'h2, 2'h0, 3'h1, 2'h0, 4'ha, 7'h33, 3'h0})
    pkt();
    `CHK(w & 32'hffe00000, {8'h06, 3'h2, 21'h0})
    pkt();
    `CHK(w & 32'hffe73fff, {8'h07, 3'h1, 2'h0, 3'h5, 2'h0, 7'h55, 7'h03})
    pkt();
    `CHK(w, {8'h03, 3'h5, 21'h12345})
    vec(7'h08, 2'h0, 3'h5, 1'b0, 1'b1, 7'h01, 7'h03);
    msg(7'h03, 2'h0, 1'b0, 21'h0);
    pkt();
    `CHK(w & 32'hffe73fff, {8'h08, 3'h4, 2'h0, 3'h5, 2'h0, 7'h01, 7'h03})
    pkt();
    `CHK(w[31:24], pager_pkt_pkg::STATUS_ID)
    vins <= 3'h7;
    vec(7'h09, 2'h3, 3'h1, 1'b0, 1'b0, 7'h12, 7'h05);
    vins <= 3'h0;
    pkt();
    `CHK(w & 32'hffe73fff, {8'h09, 3'h3, 2'h0, 3'h1, 2'h0, 4'h5, 7'h12, 3'h7})
  endtask : t_vectors
  task automatic t_overflow();
    for (int i = 0; i < 5; i++) begin
      vec(7'h0a + 7'(i), 2'h0, 3'h0, 1'b0, 1'b0, 7'h01, 7'h03);
    end
    repeat (2) @(posedge i_clk);
    `CHK({don, prompt}, 2'b01)
    pkt();
    `CHK(w & 32'hff0000d5, 32'h7f000001)
    apb(1'b0, pager_pkt_pkg::ADDR_CTRL, 32'h0);
    `CHK(r[4:0], 5'h0a)
    csum <= 1'b1;
    repeat (6) @(posedge i_clk);
    pkt();
    `CHK(w[31:24], pager_pkt_pkg::PART_ID)
  endtask : t_overflow
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK(prompt, 1'b1)
    pkt();
    `CHK(w, {8'hff, pager_pkt_pkg::MODEL_CODE, pager_pkt_pkg::COMPAT_CODE, pager_pkt_pkg::REVISION_CODE})
    t_regs();
    t_sync();
    t_flags();
    t_vectors();
    t_overflow();
    conclude();
  end
endmodule : testbench
